// *** core/swb_pkg.sv ***
// Shared constants and types of the single-wire bus status and data block.
// Assumes a 125 MHz system clock and 32-bit AXI4-Lite register access.
package swb_pkg;
	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_CONTROL = 12'h053;
	localparam logic [11:0] IDX_STATUS_ONE = 12'h054;
	localparam logic [11:0] IDX_STATUS_TWO = 12'h055;
	localparam logic [11:0] IDX_DATA_WORD = 12'h057;

	// Status one layout
	localparam int TX_EMPTY_BIT = 7;
	localparam int TX_COMPLETE_BIT = 6;
	localparam int RX_FULL_BIT = 5;
	localparam int BIT_ERROR_BIT = 3;
	localparam int NOISE_BIT = 2;
	// Status two layout
	localparam int RX_ACTIVE_BIT = 0;
	// Control layout
	localparam int RX_IRQ_EN_BIT = 5;
	localparam int BUS_SELECT_BIT = 4;
	localparam int TX_ON_BIT = 3;
	localparam int RX_ON_BIT = 2;

	localparam logic [7:0] STATUS_ONE_RESET = 8'hc0;
	localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] RX_ERROR_VALUE = 8'hff;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Sample slot is one sixteenth of a 25 us time slot
	localparam int CLK_PERIOD_PS = 8000;
	localparam int SAMPLE_SLOT_PS = 1562500;
	localparam int SAMPLE_CYCLES = SAMPLE_SLOT_PS / CLK_PERIOD_PS;
	localparam logic [3:0] SUB_LAST = 4'hf;
	localparam logic [3:0] SUB_MID_A = 4'h7;
	localparam logic [3:0] SUB_MID_B = 4'h8;
	localparam logic [3:0] SUB_MID_C = 4'h9;
	localparam logic [3:0] BIT_LAST = 4'h7;

	typedef struct packed {
		logic rx_full;
		logic bit_error;
		logic noise;
	} swb_flags_t;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} swb_rx_state_t;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} swb_tx_state_t;

	function automatic logic [13:0] byte_addr(input logic [11:0] idx);
		byte_addr = {idx, 2'b00};
	endfunction
endpackage

// *** core/swb_status_data.sv ***
// Status flags, acknowledge sequence and shared data word of the single-wire bus channel.
// Assumes synchronous line inputs, an external open-drain driver and an AXI4-Lite master.
`timescale 1ns/100ps

// Functional notes
// - Status read then data read clears flags
// - Only flags seen at status read clear
// - Receive-full sets on shifter transfer, bit 5
// - End-of-frame square wave received as characters
// - Monitored push bit mismatch sets bit error
// - Bit error never requests an interrupt
// - Queued push waits for pull field end
// - Noise during pull field sets noise flag
// - Status two bit 0 shows receiver active
// - Data read returns received pull-field word
// - Bus error reads as all ones
// - Pull bits LSB first, status into 3..1
// - Data address: write transmit, read receive
// - Push sends data bits then address bits
// - Pull sync starts reception; push inhibits receiver
// - Receive-full requests interrupt when enabled
module swb_status_data (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [13:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [13:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic bus_line_in,
	output logic bus_drive_out,
	output logic receive_irq_out
);
	logic aw_held_ff, w_held_ff, bvalid_ff, awready_ff, wready_ff;
	logic [13:0] aw_addr_ff;
	logic [7:0] w_data_ff;
	logic w_lane_ff;
	logic [1:0] bresp_ff;
	logic arready_ff, rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic nxt_aw_held, nxt_w_held, nxt_bvalid, nxt_rvalid;
	logic aw_take, w_take, wr_fire, rd_fire;
	logic [7:0] control_ff;
	logic [7:0] tx_data_ff;
	logic [7:0] rx_data_ff;
	swb_pkg::swb_flags_t flags_ff, armed_ff, flag_set, flag_clr;
	logic tx_empty_ff, tx_complete_ff;
	logic [7:0] tick_cnt_ff;
	logic tick_ff;
	swb_pkg::swb_rx_state_t rx_state_ff;
	logic [3:0] rx_sub_ff, rx_bit_ff;
	logic [7:0] rx_shift_ff;
	logic [1:0] rx_samp_ff;
	logic rx_noise_ff;
	swb_pkg::swb_tx_state_t tx_state_ff;
	logic [3:0] tx_sub_ff, tx_bit_ff;
	logic [7:0] tx_shift_ff;
	logic drive_ff, irq_ff;
	logic bus_select, rx_enabled, tx_load, tx_done, rx_done, rx_mid, rx_stop_ok;
	logic vote, vote_noisy;
	logic wr_data, wr_control, rd_status_one, rd_data, data_wr_any;
	logic [7:0] rd_value;
	logic rd_hit;

	function automatic logic addr_is(input logic [13:0] addr, input logic [11:0] idx);
		addr_is = (addr == swb_pkg::byte_addr(idx));
	endfunction

	// Order in which pull-field bits land in the receive word
	function automatic logic [2:0] pull_slot(input logic [3:0] pos);
		unique case (pos)
			4'h1: pull_slot = 3'h3;
			4'h3: pull_slot = 3'h1;
			default: pull_slot = pos[2:0];
		endcase
	endfunction

	assign bus_select = control_ff[swb_pkg::BUS_SELECT_BIT];

	// AXI4-Lite write channels, taken in either order
	assign aw_take = s_axi_awvalid_in & awready_ff;
	assign w_take = s_axi_wvalid_in & wready_ff;
	assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;

	always_comb begin
		nxt_aw_held = (aw_held_ff & ~wr_fire) | aw_take;
		nxt_w_held = (w_held_ff & ~wr_fire) | w_take;
		nxt_bvalid = (bvalid_ff & ~s_axi_bready_in) | wr_fire;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			aw_addr_ff <= 14'h0000;
			w_data_ff <= 8'h00;
			w_lane_ff <= 1'b0;
			bresp_ff <= swb_pkg::RESP_OKAY;
		end else begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff <= nxt_w_held;
			bvalid_ff <= nxt_bvalid;
			awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
			wready_ff <= ~nxt_w_held & ~nxt_bvalid;
			if (aw_take) begin
				aw_addr_ff <= s_axi_awaddr_in;
			end
			if (w_take) begin
				w_data_ff <= s_axi_wdata_in[7:0];
				w_lane_ff <= s_axi_wstrb_in[0];
			end
			if (wr_fire) begin
				bresp_ff <= (wr_data | wr_control |
					addr_is(aw_addr_ff, swb_pkg::IDX_STATUS_ONE) |
					addr_is(aw_addr_ff, swb_pkg::IDX_STATUS_TWO)) ?
					swb_pkg::RESP_OKAY : swb_pkg::RESP_SLVERR;
			end
		end
	end

	// Lane 0 carries the whole register; status registers ignore writes
	assign wr_data = wr_fire & addr_is(aw_addr_ff, swb_pkg::IDX_DATA_WORD);
	assign wr_control = wr_fire & addr_is(aw_addr_ff, swb_pkg::IDX_CONTROL);
	assign data_wr_any = wr_data & w_lane_ff;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			control_ff <= swb_pkg::CONTROL_RESET;
		end else if (wr_control && w_lane_ff) begin
			control_ff <= w_data_ff;
		end
	end

	// Transmit word keeps software packing untouched
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_data_ff <= 8'h00;
		end else if (data_wr_any) begin
			tx_data_ff <= w_data_ff;
		end
	end

	// AXI4-Lite read channel; one read outstanding
	assign rd_fire = s_axi_arvalid_in & arready_ff;
	assign rd_status_one = rd_fire & addr_is(s_axi_araddr_in, swb_pkg::IDX_STATUS_ONE);
	assign rd_data = rd_fire & addr_is(s_axi_araddr_in, swb_pkg::IDX_DATA_WORD);

	always_comb begin
		rd_value = 8'h00;
		rd_hit = 1'b1;
		if (addr_is(s_axi_araddr_in, swb_pkg::IDX_STATUS_ONE)) begin
			rd_value[swb_pkg::TX_EMPTY_BIT] = tx_empty_ff;
			rd_value[swb_pkg::TX_COMPLETE_BIT] = tx_complete_ff;
			rd_value[swb_pkg::RX_FULL_BIT] = flags_ff.rx_full;
			rd_value[swb_pkg::BIT_ERROR_BIT] = flags_ff.bit_error;
			rd_value[swb_pkg::NOISE_BIT] = flags_ff.noise;
		end else if (addr_is(s_axi_araddr_in, swb_pkg::IDX_STATUS_TWO)) begin
			rd_value[swb_pkg::RX_ACTIVE_BIT] = (rx_state_ff != swb_pkg::RX_IDLE);
		end else if (addr_is(s_axi_araddr_in, swb_pkg::IDX_DATA_WORD)) begin
			rd_value = rx_data_ff;
		end else if (addr_is(s_axi_araddr_in, swb_pkg::IDX_CONTROL)) begin
			rd_value = control_ff;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_comb begin
		nxt_rvalid = (rvalid_ff & ~s_axi_rready_in) | rd_fire;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= swb_pkg::RESP_OKAY;
		end else begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff <= nxt_rvalid;
			if (rd_fire) begin
				rdata_ff <= {24'h00_0000, rd_value};
				rresp_ff <= rd_hit ? swb_pkg::RESP_OKAY : swb_pkg::RESP_SLVERR;
			end
		end
	end

	// Acknowledge sequence: arm at status read, clear armed flags at data read
	always_comb begin
		flag_clr = '0;
		if (rd_data) begin
			flag_clr = armed_ff;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			armed_ff <= '0;
		end else if (rd_status_one) begin
			armed_ff <= flags_ff;
		end else if (rd_data) begin
			armed_ff <= '0;
		end
	end

	// Setting wins over a same-cycle acknowledge
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= (flags_ff & ~flag_clr) | flag_set;
		end
	end

	// Data write empties nothing new; a load is held off in that cycle
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_empty_ff <= swb_pkg::STATUS_ONE_RESET[swb_pkg::TX_EMPTY_BIT];
			tx_complete_ff <= swb_pkg::STATUS_ONE_RESET[swb_pkg::TX_COMPLETE_BIT];
		end else begin
			if (tx_load) begin
				tx_empty_ff <= 1'b1;
			end else if (data_wr_any) begin
				tx_empty_ff <= 1'b0;
			end
			if (tx_done && tx_empty_ff) begin
				tx_complete_ff <= 1'b1;
			end else if (data_wr_any || tx_load) begin
				tx_complete_ff <= 1'b0;
			end
		end
	end

	// Sixteen sample slots per bus time slot
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_cnt_ff <= 8'h00;
			tick_ff <= 1'b0;
		end else if (!bus_select || tick_cnt_ff == 8'(swb_pkg::SAMPLE_CYCLES - 1)) begin
			tick_cnt_ff <= 8'h00;
			tick_ff <= bus_select;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 8'h01;
			tick_ff <= 1'b0;
		end
	end

	// Pull-field receiver, three-sample majority vote
	assign rx_enabled = bus_select & control_ff[swb_pkg::RX_ON_BIT] &
		(tx_state_ff == swb_pkg::TX_IDLE);
	assign rx_mid = tick_ff & (rx_sub_ff == swb_pkg::SUB_MID_C);
	assign vote = (rx_samp_ff[0] & rx_samp_ff[1]) | (bus_line_in & (rx_samp_ff[0] | rx_samp_ff[1]));
	assign vote_noisy = ~((rx_samp_ff[0] == rx_samp_ff[1]) && (rx_samp_ff[1] == bus_line_in));
	assign rx_done = rx_mid & (rx_state_ff == swb_pkg::RX_STOP);
	assign rx_stop_ok = vote;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_state_ff <= swb_pkg::RX_IDLE;
			rx_sub_ff <= 4'h0;
			rx_bit_ff <= 4'h0;
			rx_shift_ff <= 8'h00;
			rx_samp_ff <= 2'b00;
			rx_noise_ff <= 1'b0;
		end else if (!rx_enabled) begin
			rx_state_ff <= swb_pkg::RX_IDLE;
		end else if (rx_state_ff == swb_pkg::RX_IDLE) begin
			rx_sub_ff <= 4'h0;
			rx_bit_ff <= 4'h0;
			rx_noise_ff <= 1'b0;
			if (!bus_line_in) begin
				rx_state_ff <= swb_pkg::RX_START;
			end
		end else if (tick_ff) begin
			rx_sub_ff <= rx_sub_ff + 4'h1;
			if (rx_sub_ff == swb_pkg::SUB_MID_A) begin
				rx_samp_ff[0] <= bus_line_in;
			end
			if (rx_sub_ff == swb_pkg::SUB_MID_B) begin
				rx_samp_ff[1] <= bus_line_in;
			end
			if (rx_sub_ff == swb_pkg::SUB_MID_C) begin
				rx_noise_ff <= rx_noise_ff | vote_noisy;
			end
			unique case (rx_state_ff)
				swb_pkg::RX_START: begin
					// A glitch is not a pull sync
					if (rx_sub_ff == swb_pkg::SUB_MID_C && vote) begin
						rx_state_ff <= swb_pkg::RX_IDLE;
					end else if (rx_sub_ff == swb_pkg::SUB_LAST) begin
						rx_state_ff <= swb_pkg::RX_DATA;
					end
				end
				swb_pkg::RX_DATA: begin
					if (rx_sub_ff == swb_pkg::SUB_MID_C) begin
						rx_shift_ff[pull_slot(rx_bit_ff)] <= vote;
					end
					if (rx_sub_ff == swb_pkg::SUB_LAST) begin
						rx_bit_ff <= rx_bit_ff + 4'h1;
						if (rx_bit_ff == swb_pkg::BIT_LAST) begin
							rx_state_ff <= swb_pkg::RX_STOP;
						end
					end
				end
				swb_pkg::RX_STOP: begin
					// Back to idle mid stop bit so the next edge is caught
					if (rx_sub_ff == swb_pkg::SUB_MID_C) begin
						rx_state_ff <= swb_pkg::RX_IDLE;
					end
				end
				swb_pkg::RX_IDLE: begin
					rx_state_ff <= swb_pkg::RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_data_ff <= 8'h00;
		end else if (rx_done) begin
			rx_data_ff <= rx_stop_ok ? rx_shift_ff : swb_pkg::RX_ERROR_VALUE;
		end
	end

	// Push-field transmitter with bit monitoring
	// Load waits for a tick so the start bit is a whole slot
	assign tx_load = bus_select & control_ff[swb_pkg::TX_ON_BIT] & ~tx_empty_ff & ~data_wr_any &
		tick_ff & (tx_state_ff == swb_pkg::TX_IDLE) & (rx_state_ff == swb_pkg::RX_IDLE);
	assign tx_done = tick_ff & (tx_state_ff == swb_pkg::TX_STOP) & (tx_sub_ff == swb_pkg::SUB_LAST);

	always_comb begin
		flag_set = '0;
		flag_set.rx_full = rx_done;
		flag_set.noise = rx_done & (rx_noise_ff | vote_noisy);
		flag_set.bit_error = tick_ff & (tx_state_ff == swb_pkg::TX_DATA) &
			(tx_sub_ff == swb_pkg::SUB_MID_B) & (bus_line_in != tx_shift_ff[0]);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_state_ff <= swb_pkg::TX_IDLE;
			tx_sub_ff <= 4'h0;
			tx_bit_ff <= 4'h0;
			tx_shift_ff <= 8'h00;
			drive_ff <= 1'b1;
		end else if (!bus_select) begin
			tx_state_ff <= swb_pkg::TX_IDLE;
			drive_ff <= 1'b1;
		end else if (tx_load) begin
			tx_shift_ff <= tx_data_ff;
			tx_sub_ff <= 4'h0;
			tx_bit_ff <= 4'h0;
			tx_state_ff <= swb_pkg::TX_START;
			drive_ff <= 1'b0;
		end else if (tick_ff && tx_state_ff != swb_pkg::TX_IDLE) begin
			tx_sub_ff <= tx_sub_ff + 4'h1;
			if (tx_sub_ff == swb_pkg::SUB_LAST) begin
				unique case (tx_state_ff)
					swb_pkg::TX_START: begin
						tx_state_ff <= swb_pkg::TX_DATA;
						drive_ff <= tx_shift_ff[0];
					end
					swb_pkg::TX_DATA: begin
						// Data bits [4:0] leave first, then address [7:5]
						tx_shift_ff <= {1'b1, tx_shift_ff[7:1]};
						tx_bit_ff <= tx_bit_ff + 4'h1;
						if (tx_bit_ff == swb_pkg::BIT_LAST) begin
							tx_state_ff <= swb_pkg::TX_STOP;
							drive_ff <= 1'b1;
						end else begin
							drive_ff <= tx_shift_ff[1];
						end
					end
					swb_pkg::TX_STOP: begin
						tx_state_ff <= swb_pkg::TX_IDLE;
					end
					swb_pkg::TX_IDLE: begin
						tx_state_ff <= swb_pkg::TX_IDLE;
					end
				endcase
			end
		end
	end

	// Bit error is left out of the request in bus mode
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= control_ff[swb_pkg::RX_IRQ_EN_BIT] & flags_ff.rx_full;
		end
	end

	assign s_axi_awready_out = awready_ff;
	assign s_axi_wready_out = wready_ff;
	assign s_axi_bresp_out = bresp_ff;
	assign s_axi_bvalid_out = bvalid_ff;
	assign s_axi_arready_out = arready_ff;
	assign s_axi_rdata_out = rdata_ff;
	assign s_axi_rresp_out = rresp_ff;
	assign s_axi_rvalid_out = rvalid_ff;
	assign bus_drive_out = drive_ff;
	assign receive_irq_out = irq_ff;
endmodule // swb_status_data

// *** test/swb_status_data_monitor.sv ***
// Port checker of the single-wire bus status and data block.
// Assumes one clock domain, bound to the design top below.
`timescale 1ns/100ps
module swb_status_data_monitor (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic [13:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0] s_axi_rresp_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic bus_drive_out,
	input wire logic receive_irq_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [13:0] ar_addr_ff;
	logic [15:0] low_run_ff;
	logic wrote_ff;
	logic mapped;
	assign mapped = ar_addr_ff inside {14'h014c, 14'h0150, 14'h0154, 14'h015c};
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) ar_addr_ff <= 14'h0000;
		else if (s_axi_arvalid_in && s_axi_arready_out) ar_addr_ff <= s_axi_araddr_in;
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) wrote_ff <= 1'b0;
		else if (s_axi_awvalid_in && s_axi_awready_out) wrote_ff <= 1'b1;
	end
	// Counts a dominant run; frames must keep whole bit slots
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) low_run_ff <= 16'h0000;
		else if (!bus_drive_out) low_run_ff <= low_run_ff + 16'h0001;
		else low_run_ff <= 16'h0000;
	end
	AST_R_AFTER: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");
	AST_B_AFTER: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
		s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out)
		else $error("write answer late");
	AST_AW_BLOCK: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken while response pending");
	AST_AR_BLOCK: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read taken while data pending");
	AST_R_ONCE: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
		else $error("read data repeated");
	AST_RDATA_UPPER: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
		else $error("upper read bits set");
	AST_RRESP_MAP: assert property (s_axi_rvalid_out |-> s_axi_rresp_out == (mapped ? 2'h0 : 2'h2))
		else $error("read response code wrong");
	AST_STATUS_TWO: assert property (s_axi_rvalid_out && ar_addr_ff == 14'h0154 |->
		s_axi_rdata_out[7:1] == 7'h00)
		else $error("status two upper bits set");
	AST_DRIVE_IDLE: assert property (!wrote_ff |-> bus_drive_out)
		else $error("line driven without a written word");
	AST_DRIVE_SLOT: assert property ($rose(bus_drive_out) |->
		low_run_ff % (swb_pkg::SAMPLE_CYCLES * 16) == 0)
		else $error("dominant run not whole slots");
	cover property ($rose(receive_irq_out));
	cover property ($rose(s_axi_bvalid_out));
	cover property ($fell(bus_drive_out));
endmodule // swb_status_data_monitor

bind swb_status_data swb_status_data_monitor u_mon (.clk_in, .rst_n_in, .s_axi_awvalid_in,
	.s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_araddr_in,
	.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
	.s_axi_rready_in, .bus_drive_out, .receive_irq_out);

// *** test/swb_remote_slave.sv ***
// Remote slave on the single-wire bus: sends pull frames, can clamp the line.
// Assumes a pulled-up wired-AND line; released means recessive.
`timescale 1ns/100ps
module swb_remote_slave (
	input wire logic clk_in,
	input wire logic send_in,
	input wire logic [9:0] frame_in,
	input wire logic [3:0] noisy_in,
	input wire logic clamp_in,
	output logic line_out
);
	logic level;
	initial level = 1'b1;
	assign line_out = level & !clamp_in;
	// Short glitch mid-slot upsets one vote only
	always @(posedge send_in) begin
		for (int k = 0; k < 10; k++) begin
			level <= frame_in[k];
			if (k == noisy_in) begin
				repeat (1480) @(posedge clk_in);
				level <= ~frame_in[k];
				repeat (180) @(posedge clk_in);
				level <= frame_in[k];
				repeat (1460) @(posedge clk_in);
			end else
				repeat (3120) @(posedge clk_in);
		end
		level <= 1'b1;
	end
endmodule // swb_remote_slave

// *** test/swb_status_data_test.sv ***
// Bench of the single-wire bus status and data block.
// Assumes the remote slave model and bus-speaking tasks below.
`timescale 1ns/100ps
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
	$display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module swb_status_data_test;
	localparam logic [13:0] A_CTL = 14'h014c;
	localparam logic [13:0] A_S1 = 14'h0150;
	localparam logic [13:0] A_S2 = 14'h0154;
	localparam logic [13:0] A_DW = 14'h015c;
	localparam logic [13:0] A_BAD = 14'h0158;
	logic clk_in, rst_n_in, awvalid, wvalid, arvalid, send, clamp, bus_line, slave_line;
	logic awready, wready, bvalid, arready, rvalid, bus_drive_out, receive_irq_out;
	logic [13:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [9:0] frame;
	logic [3:0] noisy;
	int errors, n_compared;
	assign bus_line = slave_line & bus_drive_out;
	swb_status_data DUT (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'h1),
		.s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(1'b1),
		.s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(1'b1),
		.bus_line_in(bus_line),
		.bus_drive_out(bus_drive_out),
		.receive_irq_out(receive_irq_out)
	);
	swb_remote_slave u_slave (
		.clk_in(clk_in),
		.send_in(send),
		.frame_in(frame),
		.noisy_in(noisy),
		.clamp_in(clamp),
		.line_out(slave_line)
	);
	always #4 clk_in = ~clk_in;
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Ready channels release independently; response taken at once
	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk_in);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
	endtask
	task automatic rd(input logic [13:0] a, output logic [7:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk_in);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata[7:0];
		r = rresp;
	endtask
	task automatic chk(input logic [13:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHECK(d, e)
	endtask
	initial begin
		repeat (90000) @(posedge clk_in);
		errors++;
		test_done();
	end
	initial begin
		logic [7:0] d;
		logic [1:0] r;
		logic [7:0] w;
		clk_in = 1'b0;
		rst_n_in = 1'b0;
		{awvalid, wvalid, arvalid, send, clamp} = 5'h00;
		{awaddr, araddr, wdata, frame, noisy} = '0;
		errors = 0;
		n_compared = 0;
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		chk(A_S1, 8'hc0);
		chk(A_S2, 8'h00);
		rd(A_BAD, d, r);
		`CHECK(r, 2'h2)
		$display("reset test done");
		wr(A_CTL, 8'h3c);
		frame <= {1'b1, 8'h57, 1'b0};
		noisy <= 4'h3;
		send <= 1'b1;
		@(posedge clk_in);
		send <= 1'b0;
		repeat (15000) @(posedge clk_in);
		chk(A_S2, 8'h01);
		`CHECK(receive_irq_out, 1'b0)
		while (receive_irq_out !== 1'b1) @(posedge clk_in);
		// Status bits arrive swapped end for end
		chk(A_DW, 8'h5d);
		chk(A_S1, 8'he4);
		$display("pull test done");
		w = {3'h5, 5'h05};
		wr(A_DW, w);
		while (bus_drive_out !== 1'b0) @(posedge clk_in);
		repeat (3119) @(posedge clk_in);
		for (int k = 0; k < 8; k++) begin
			if (k == 0) clamp <= 1'b1;
			repeat (1560) @(posedge clk_in);
			`CHECK(bus_drive_out, w[k])
			repeat (1560) @(posedge clk_in);
			clamp <= 1'b0;
		end
		repeat (3200) @(posedge clk_in);
		chk(A_DW, 8'h5d);
		chk(A_S1, 8'hc8);
		`CHECK(receive_irq_out, 1'b0)
		chk(A_DW, 8'h5d);
		chk(A_S1, 8'hc0);
		$display("push test done");
		wr(A_CTL, 8'h38);
		`CHECK(bresp, 2'h0)
		chk(A_S2, 8'h00);
		wr(A_CTL, 8'h1c);
		`CHECK(receive_irq_out, 1'b0)
		wr(A_BAD, 8'h00);
		`CHECK(bresp, 2'h2)
		$display("mode test done");
		test_done();
	end
endmodule // swb_status_data_test
